// ---- rtl/tsw_trap_window_regs.sv ----
// Purpose: Trap stack, trap table base, version and window state registers
// Assumes: Privileged read/write port, trap and window events from the core
// Notes:   Read data and the illegal flag appear one cycle after the request
//
// Functional notes
// [RULE1] Five saved-state registers, one per trap level, hold previous level.
// [RULE2] Saved state: codes 39:32, space id 31:24, state 19:8, window 4:0.
// [RULE3] Only current-depth saved state accessible; depth zero access is illegal.
// [RULE4] Saved state above depth and after reset is undefined, not initialised.
// [RULE5] Trap kind per level holds the entering trap type, reset type too.
// [RULE6] Trap kind access at depth zero illegal; else current level accessed.
// [RULE7] After reset top-level trap kind reads 001, others undefined.
// [RULE8] Table base keeps upper 49 bits; lower 15 read zero, writes dropped.
// [RULE9] Vector is base, depth flag, new trap kind, five zeros.
// [RULE10] Depth flag is 0 when trapping from depth zero, else 1.
// [RULE11] Version register is read-only and readable by privileged read.
// [RULE12] Version has optional 16-bit maker field; implementation code not FFF0-FFFF.
// [RULE13] Version max trap depth reads 5, max window index reads 7.
// [RULE14] Window index and counters keep 3 bits; upper bits read zero.
// [RULE15] Save increments window index, restore decrements it.
// [RULE16] Among traps, only spill or fill traps change the window index.
// [RULE17] Free count gives windows a save may allocate without spilling.
// [RULE18] Refillable count gives windows a restore may reach without filling.
// [RULE19] Spill/fill traps insert handler select into kind 4:2, by foreign count.
// [RULE20] Save needing a clean window with none available raises clean exception.
// [RULE21] Clean count includes refillable windows plus clean ones ahead.
// [RULE22] Software keeps counters below 7 and clean at most 6; unchecked.
// [RULE23] Five trap levels; depth is set to five after reset.
// [RULE24] Trap entry writes the newly incremented level in the same cycle.

module tsw_trap_window_regs #(
  parameter logic [15:0] MAKER_CODE = 16'h0000, // Arbitrary value
  parameter logic [15:0] IMPL_CODE = 16'h0001, // Arbitrary value
  parameter logic [7:0] MASK_REV = 8'h01 // Arbitrary value
) (
  input wire logic core_clk, // Core clock, 100 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic pr_rd_en, // Privileged read request
  input wire logic pr_wr_en, // Privileged write request
  input wire logic [tsw_pkg::SEL_W-1:0] pr_sel, // Register select
  input wire logic [63:0] pr_wdata, // Write data
  output logic [63:0] pr_rdata, // Read data, registered
  output logic pr_illegal, // Illegal access pulse
  input wire logic trap_take, // Trap entry strobe
  input wire logic [tsw_pkg::KIND_W-1:0] trap_type, // Type of trap taken
  input wire logic trap_spill, // Trap is a window spill
  input wire logic trap_fill, // Trap is a window fill
  input wire logic [7:0] cur_codes, // Current condition codes
  input wire logic [7:0] cur_space_id, // Current address space id
  input wire logic [11:0] cur_proc_state, // Current processor state
  input wire logic trap_return, // Return from trap strobe
  output logic [tsw_pkg::STATE_W-1:0] ret_saved_state, // Current level state
  output logic [63:0] trap_vector, // Vector of last trap
  input wire logic win_save, // Window save request
  input wire logic win_restore, // Window restore request
  output logic win_spill_exc, // Spill exception pulse
  output logic win_fill_exc, // Fill exception pulse
  output logic win_clean_exc, // Clean-window exception pulse
  output logic [tsw_pkg::DEPTH_W-1:0] trap_depth, // Current trap depth
  output logic [tsw_pkg::WIN_W-1:0] current_window_index // Current window
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [tsw_pkg::DEPTH_W-1:0] depth_r;
  logic [63:tsw_pkg::BASE_LO] base_r;
  logic [tsw_pkg::WIN_W-1:0] cwi_r;
  logic [tsw_pkg::WIN_W-1:0] free_r;
  logic [tsw_pkg::WIN_W-1:0] refill_r;
  logic [tsw_pkg::WIN_W-1:0] foreign_r;
  logic [tsw_pkg::WIN_W-1:0] clean_r;
  logic [tsw_pkg::WSEL_W-1:0] wsel_r;
  logic [63:0] rdata_r;
  logic illegal_r;
  logic [63:0] vector_r;
  logic spill_r;
  logic fill_r;
  logic clean_exc_r;

  logic [tsw_pkg::STATE_W-1:0] lvl_state [tsw_pkg::MAX_DEPTH];
  logic [tsw_pkg::KIND_W-1:0] lvl_kind [tsw_pkg::MAX_DEPTH];
  logic [tsw_pkg::MAX_DEPTH-1:0] lvl_wr;
  logic [tsw_pkg::STATE_W-1:0] lvl_window_handler_select;
  logic [tsw_pkg::KIND_W-1:0] lvl_wkind;

  logic [tsw_pkg::DEPTH_W-1:0] acc_idx;
  logic [tsw_pkg::DEPTH_W-1:0] depth_nxt;
  logic [tsw_pkg::DEPTH_W-1:0] new_idx;
  logic [tsw_pkg::KIND_W-1:0] kind_nxt;
  logic [tsw_pkg::STATE_W-1:0] trap_state;
  logic [tsw_pkg::STATE_W-1:0] wr_state_fmt;
  logic [tsw_pkg::STATE_W-1:0] cur_state;
  logic [tsw_pkg::KIND_W-1:0] cur_kind;
  logic [63:0] ver_val;
  logic [63:0] rd_val;
  logic rd_bad;
  logic depth_zero;
  logic win_go;
  logic save_ok;
  logic restore_ok;
  logic wr_hit_saved;
  logic wr_hit_kind;

  // ****************************************************************
  // Level selection and trap entry values
  // ****************************************************************

  // Current level index and next level on a trap
  assign depth_zero = (depth_r == 3'h0);
  assign acc_idx = depth_zero ? 3'h0 : depth_r - 3'h1;
  assign depth_nxt = (depth_r == tsw_pkg::DEPTH_MAX) ?
                     tsw_pkg::DEPTH_MAX : depth_r + 3'h1;
  assign new_idx = depth_nxt - 3'h1;

  // [RULE19] handler select insertion
  always_comb begin
    kind_nxt = trap_type;
    if (trap_spill || trap_fill) begin
      if (foreign_r == 3'h0) begin
        kind_nxt[tsw_pkg::KIND_INS_HI:tsw_pkg::KIND_INS_LO] =
          wsel_r[tsw_pkg::WSEL_NORM_LO +: tsw_pkg::WIN_W];
      end else begin
        kind_nxt[tsw_pkg::KIND_INS_HI:tsw_pkg::KIND_INS_LO] =
          wsel_r[tsw_pkg::WSEL_OTH_LO +: tsw_pkg::WIN_W];
      end
    end
  end

  // [RULE2] saved state packing
  always_comb begin
    trap_state = '0;
    trap_state[tsw_pkg::CC_HI:tsw_pkg::CC_LO] = cur_codes;
    trap_state[tsw_pkg::ASID_HI:tsw_pkg::ASID_LO] = cur_space_id;
    trap_state[tsw_pkg::PST_HI:tsw_pkg::PST_LO] = cur_proc_state;
    trap_state[tsw_pkg::CWI_LO +: tsw_pkg::WIN_W] = cwi_r;
    wr_state_fmt = '0;
    wr_state_fmt[tsw_pkg::CC_HI:tsw_pkg::CC_LO] =
      pr_wdata[tsw_pkg::CC_HI:tsw_pkg::CC_LO];
    wr_state_fmt[tsw_pkg::ASID_HI:tsw_pkg::ASID_LO] =
      pr_wdata[tsw_pkg::ASID_HI:tsw_pkg::ASID_LO];
    wr_state_fmt[tsw_pkg::PST_HI:tsw_pkg::PST_LO] =
      pr_wdata[tsw_pkg::PST_HI:tsw_pkg::PST_LO];
    wr_state_fmt[tsw_pkg::CWI_LO +: tsw_pkg::WIN_W] =
      pr_wdata[tsw_pkg::CWI_LO +: tsw_pkg::WIN_W];
  end

  // ****************************************************************
  // Per-level storage
  // ****************************************************************

  // Privileged writes to the current level, refused at depth zero
  assign wr_hit_saved = pr_wr_en && !trap_take && !depth_zero &&
                        (pr_sel == tsw_pkg::SEL_SAVED);
  assign wr_hit_kind = pr_wr_en && !trap_take && !depth_zero &&
                       (pr_sel == tsw_pkg::SEL_KIND);

  // [RULE24] trap entry writes new level
  always_comb begin
    lvl_wr = '0;
    lvl_window_handler_select = trap_state;
    // [RULE5] entering trap type kept
    lvl_wkind = kind_nxt;
    if (trap_take) begin
      lvl_wr[new_idx] = 1'b1;
    end else if (wr_hit_saved || wr_hit_kind) begin
      // [RULE3] current level only
      lvl_wr[acc_idx] = 1'b1;
      lvl_window_handler_select = wr_hit_saved ? wr_state_fmt : cur_state;
      lvl_wkind = wr_hit_kind ? pr_wdata[tsw_pkg::KIND_W-1:0] : cur_kind;
    end
  end

  // [RULE1] one entry per level
  generate
    for (genvar i = 0; i < tsw_pkg::MAX_DEPTH; i++) begin : g_lvl
      tsw_level_entry #(
        .KIND_RESETS(i == tsw_pkg::MAX_DEPTH - 1)
      ) u_entry (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_en(lvl_wr[i]),
        .wr_state(lvl_window_handler_select),
        .wr_kind(lvl_wkind),
        .state_q(lvl_state[i]),
        .kind_q(lvl_kind[i])
      );
    end
  endgenerate

  assign cur_state = lvl_state[acc_idx];
  assign cur_kind = lvl_kind[acc_idx];
  assign ret_saved_state = cur_state;

  // ****************************************************************
  // Trap depth and trap vector
  // ****************************************************************

  // [RULE23] depth resets to five
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      depth_r <= tsw_pkg::POR_DEPTH;
    end else if (trap_take) begin
      depth_r <= depth_nxt;
    end else if (trap_return && !depth_zero) begin
      depth_r <= depth_r - 3'h1;
    end else if (pr_wr_en && pr_sel == tsw_pkg::SEL_DEPTH) begin
      if (pr_wdata > 64'h5) begin
        depth_r <= tsw_pkg::DEPTH_MAX;
      end else begin
        depth_r <= pr_wdata[tsw_pkg::DEPTH_W-1:0];
      end
    end
  end

  // [RULE9] vector formation
  // [RULE10] depth flag from old depth
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_r <= 64'h0;
    end else if (trap_take) begin
      vector_r <= {base_r, !depth_zero, kind_nxt, 5'h00};
    end
  end

  // [RULE8] base keeps upper bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_r <= '0;
    end else if (pr_wr_en && pr_sel == tsw_pkg::SEL_BASE) begin
      base_r <= pr_wdata[63:tsw_pkg::BASE_LO];
    end
  end

  // ****************************************************************
  // Window state
  // ****************************************************************

  // [RULE22] limits are unchecked, software keeps them
  assign win_go = !trap_take && !trap_return;
  // [RULE17] save allowed while free windows remain
  // [RULE20] clean window needed and none left
  assign save_ok = win_go && win_save && (free_r != 3'h0) &&
                   (clean_r != refill_r);
  // [RULE18] restore allowed while refillable windows remain
  assign restore_ok = win_go && win_restore && !win_save &&
                      (refill_r != 3'h0);

  // Current window index
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cwi_r <= tsw_pkg::WIN_RST;
    end else if (trap_take) begin
      // [RULE16] only spill or fill move it
      if (trap_spill) begin
        cwi_r <= cwi_r + free_r + tsw_pkg::SPILL_STEP;
      end else if (trap_fill) begin
        cwi_r <= cwi_r - 3'h1;
      end
    end else if (trap_return) begin
      if (!depth_zero) begin
        cwi_r <= cur_state[tsw_pkg::CWI_LO +: tsw_pkg::WIN_W];
      end
    end else if (pr_wr_en && pr_sel == tsw_pkg::SEL_CWI) begin
      // [RULE14] upper bits ignored
      cwi_r <= pr_wdata[tsw_pkg::WIN_W-1:0];
    end else if (save_ok) begin
      // [RULE15] save increments
      cwi_r <= cwi_r + 3'h1;
    end else if (restore_ok) begin
      // [RULE15] restore decrements
      cwi_r <= cwi_r - 3'h1;
    end
  end

  // Free and refillable counters track saves and restores
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      free_r <= tsw_pkg::WIN_RST;
      refill_r <= tsw_pkg::WIN_RST;
    end else begin
      if (pr_wr_en && pr_sel == tsw_pkg::SEL_FREE) begin
        free_r <= pr_wdata[tsw_pkg::WIN_W-1:0];
      end else if (save_ok) begin
        free_r <= free_r - 3'h1;
      end else if (restore_ok) begin
        free_r <= free_r + 3'h1;
      end
      if (pr_wr_en && pr_sel == tsw_pkg::SEL_REFILL) begin
        refill_r <= pr_wdata[tsw_pkg::WIN_W-1:0];
      end else if (save_ok) begin
        refill_r <= refill_r + 3'h1;
      end else if (restore_ok) begin
        refill_r <= refill_r - 3'h1;
      end
    end
  end

  // [RULE21] clean count spans refillable plus clean ahead
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clean_r <= tsw_pkg::WIN_RST;
      foreign_r <= tsw_pkg::WIN_RST;
      wsel_r <= '0;
    end else if (pr_wr_en) begin
      if (pr_sel == tsw_pkg::SEL_CLEAN) begin
        clean_r <= pr_wdata[tsw_pkg::WIN_W-1:0];
      end
      if (pr_sel == tsw_pkg::SEL_FOREIGN) begin
        foreign_r <= pr_wdata[tsw_pkg::WIN_W-1:0];
      end
      if (pr_sel == tsw_pkg::SEL_WSEL) begin
        wsel_r <= pr_wdata[tsw_pkg::WSEL_W-1:0];
      end
    end
  end

  // Window exception pulses
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      spill_r <= 1'b0;
      fill_r <= 1'b0;
      clean_exc_r <= 1'b0;
    end else begin
      spill_r <= win_go && win_save && (free_r == 3'h0);
      fill_r <= win_go && win_restore && !win_save && (refill_r == 3'h0);
      // [RULE20] clean exception
      clean_exc_r <= win_go && win_save && (free_r != 3'h0) &&
                     (clean_r == refill_r);
    end
  end

  // ****************************************************************
  // Privileged read path
  // ****************************************************************

  // [RULE11] fixed version value
  // [RULE12] maker and implementation fields
  // [RULE13] depth and window limits
  always_comb begin
    ver_val = 64'h0;
    ver_val[tsw_pkg::VER_MAKER_LO +: 16] = MAKER_CODE;
    ver_val[tsw_pkg::IMPLEMENTATION_FIELD_LO +: 16] = IMPL_CODE;
    ver_val[tsw_pkg::VER_MASK_LO +: 8] = MASK_REV;
    ver_val[tsw_pkg::VER_MAXTL_LO +: 8] = tsw_pkg::VER_MAXTL;
    ver_val[tsw_pkg::MAX_WINDOW_INDEX_LO +: 5] = tsw_pkg::MAX_WINDOW_INDEX;
  end

  // Read mux; unknown selects and depth-zero stack reads are illegal
  always_comb begin
    rd_val = 64'h0;
    rd_bad = 1'b0;
    case (pr_sel)
      tsw_pkg::SEL_SAVED: begin
        // [RULE3] depth zero illegal
        rd_bad = depth_zero;
        rd_val = depth_zero ? 64'h0 : {24'h0, cur_state};
      end
      tsw_pkg::SEL_KIND: begin
        // [RULE6] depth zero illegal
        rd_bad = depth_zero;
        rd_val = depth_zero ? 64'h0 : {55'h0, cur_kind};
      end
      tsw_pkg::SEL_BASE: rd_val = {base_r, 15'h0000};
      tsw_pkg::SEL_DEPTH: rd_val = {61'h0, depth_r};
      // [RULE14] upper bits read zero
      tsw_pkg::SEL_CWI: rd_val = {61'h0, cwi_r};
      tsw_pkg::SEL_FREE: rd_val = {61'h0, free_r};
      tsw_pkg::SEL_REFILL: rd_val = {61'h0, refill_r};
      tsw_pkg::SEL_CLEAN: rd_val = {61'h0, clean_r};
      tsw_pkg::SEL_FOREIGN: rd_val = {61'h0, foreign_r};
      tsw_pkg::SEL_WSEL: rd_val = {58'h0, wsel_r};
      tsw_pkg::SEL_VER: rd_val = ver_val;
      default: rd_bad = 1'b1;
    endcase
  end

  // Registered answer; writes to the version register are illegal
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 64'h0;
      illegal_r <= 1'b0;
    end else begin
      if (pr_rd_en) begin
        rdata_r <= rd_val;
      end
      illegal_r <= (pr_rd_en && rd_bad) ||
                   (pr_wr_en && (rd_bad || pr_sel == tsw_pkg::SEL_VER));
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pr_rdata = rdata_r;
  assign pr_illegal = illegal_r;
  assign trap_vector = vector_r;
  assign win_spill_exc = spill_r;
  assign win_fill_exc = fill_r;
  assign win_clean_exc = clean_exc_r;
  assign trap_depth = depth_r;
  assign current_window_index = cwi_r;

endmodule

// ---- common/tsw_pkg.sv ----
// Purpose: Shared constants for the trap stack and window state registers
// Assumes: 64-bit privileged data path, five trap levels, eight windows
// Notes:   Register select codes address the privileged read/write port

package tsw_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int MAX_DEPTH = 5;
  localparam int DEPTH_W = 3;
  localparam int WIN_W = 3;
  localparam int KIND_W = 9;
  localparam int STATE_W = 40;
  localparam int SEL_W = 5;
  localparam int WSEL_W = 6;
  localparam int BASE_LO = 15;
  localparam int VEC_ZERO_W = 5;

  // ****************************************************************
  // Saved-state field positions
  // ****************************************************************
  localparam int CC_HI = 39;
  localparam int CC_LO = 32;
  localparam int ASID_HI = 31;
  localparam int ASID_LO = 24;
  localparam int PST_HI = 19;
  localparam int PST_LO = 8;
  localparam int CWI_HI = 4;
  localparam int CWI_LO = 0;

  // Handler-select fields and trap-kind insertion bits
  localparam int WSEL_NORM_LO = 0;
  localparam int WSEL_OTH_LO = 3;
  localparam int KIND_INS_HI = 4;
  localparam int KIND_INS_LO = 2;

  // ****************************************************************
  // Version register fields
  // ****************************************************************
  localparam int VER_MAKER_LO = 48;
  localparam int IMPLEMENTATION_FIELD_LO = 32;
  localparam int VER_MASK_LO = 24;
  localparam int VER_MAXTL_LO = 8;
  localparam int MAX_WINDOW_INDEX_LO = 0;
  localparam logic [7:0] VER_MAXTL = 8'h05;
  localparam logic [4:0] MAX_WINDOW_INDEX = 5'h07;

  // ****************************************************************
  // Reset values, depth limit and spill step
  // ****************************************************************
  localparam logic [KIND_W-1:0] POR_KIND = 9'h001;
  localparam logic [DEPTH_W-1:0] POR_DEPTH = 3'h5;
  localparam logic [DEPTH_W-1:0] DEPTH_MAX = 3'h5;
  localparam logic [WIN_W-1:0] WIN_RST = 3'h0;
  localparam logic [WIN_W-1:0] SPILL_STEP = 3'h2;

  // ****************************************************************
  // Privileged register select codes
  // ****************************************************************
  localparam logic [SEL_W-1:0] SEL_SAVED = 5'h02;
  localparam logic [SEL_W-1:0] SEL_KIND = 5'h03;
  localparam logic [SEL_W-1:0] SEL_BASE = 5'h05;
  localparam logic [SEL_W-1:0] SEL_DEPTH = 5'h07;
  localparam logic [SEL_W-1:0] SEL_CWI = 5'h09;
  localparam logic [SEL_W-1:0] SEL_FREE = 5'h0a;
  localparam logic [SEL_W-1:0] SEL_REFILL = 5'h0b;
  localparam logic [SEL_W-1:0] SEL_CLEAN = 5'h0c;
  localparam logic [SEL_W-1:0] SEL_FOREIGN = 5'h0d;
  localparam logic [SEL_W-1:0] SEL_WSEL = 5'h0e;
  localparam logic [SEL_W-1:0] SEL_VER = 5'h1f;

endpackage

// ---- rtl/tsw_level_entry.sv ----
// Purpose: One trap level's saved-state and trap-kind storage
// Assumes: Single clock, writes take effect at the next edge
// Notes:   Saved state has no reset; trap kind resets only when asked

module tsw_level_entry #(
  parameter bit KIND_RESETS = 1'b0
) (
  input wire logic core_clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic wr_en, // Load both fields
  input wire logic [tsw_pkg::STATE_W-1:0] wr_state, // Saved state in
  input wire logic [tsw_pkg::KIND_W-1:0] wr_kind, // Trap kind in
  output logic [tsw_pkg::STATE_W-1:0] state_q, // Saved state held
  output logic [tsw_pkg::KIND_W-1:0] kind_q // Trap kind held
);

  // ****************************************************************
  // Storage
  // ****************************************************************

  // [RULE4] no initialisation
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      state_q <= wr_state;
    end
  end

  generate
    if (KIND_RESETS) begin : g_rst
      // [RULE7] top kind reset
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          kind_q <= tsw_pkg::POR_KIND;
        end else if (wr_en) begin
          kind_q <= wr_kind;
        end
      end
    end else begin : g_nrst
      always_ff @(posedge core_clk) begin
        if (wr_en) begin
          kind_q <= wr_kind;
        end
      end
    end
  endgenerate

endmodule

// ---- verification/tsw_trap_window_properties.sv ----
// Purpose: Port assertions
// Assumes: Sees only the top-level ports
// Notes:   Bound from the testbench top file
module tsw_trap_window_properties (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic pr_rd_en, // Read
  input wire logic pr_wr_en, // Write
  input wire logic [tsw_pkg::SEL_W-1:0] pr_sel, // Select
  input wire logic [63:0] pr_rdata, // Read data
  input wire logic pr_illegal, // Illegal
  input wire logic trap_take, // Trap
  input wire logic trap_return, // Return
  input wire logic [63:0] trap_vector, // Vector
  input wire logic win_save, // Save
  input wire logic win_restore, // Restore
  input wire logic win_spill_exc, // Spill
  input wire logic win_clean_exc, // Clean
  input wire logic [tsw_pkg::DEPTH_W-1:0] trap_depth, // Depth
  input wire logic [tsw_pkg::WIN_W-1:0] current_window_index // Window
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  stack_at_zero_a:
  assert property ((pr_rd_en || pr_wr_en) && trap_depth == 3'h0 &&
    (pr_sel == tsw_pkg::SEL_SAVED || pr_sel == tsw_pkg::SEL_KIND)
    |=> pr_illegal) else $error("depth zero access");
  version_fields_a:
  assert property (pr_rd_en && pr_sel == tsw_pkg::SEL_VER |=>
    pr_rdata[15:8] == 8'h05 && pr_rdata[4:0] == 5'h07 && !pr_illegal)
    else $error("version field wrong");
  counter_upper_a:
  assert property (pr_rd_en && pr_sel >= tsw_pkg::SEL_CWI &&
    pr_sel <= tsw_pkg::SEL_FOREIGN |=> pr_rdata[63:3] == 61'h0)
    else $error("counter upper bits");
  base_low_a:
  assert property (pr_rd_en && pr_sel == tsw_pkg::SEL_BASE |=>
    pr_rdata[14:0] == 15'h0) else $error("base low bits set");
  depth_step_a:
  assert property (trap_take |=> trap_depth == ($past(trap_depth) == 3'h5
    ? 3'h5 : $past(trap_depth) + 3'h1)) else $error("depth step wrong");
  vector_form_a:
  assert property (trap_take |=> trap_vector[4:0] == 5'h0 &&
    trap_vector[14] == ($past(trap_depth) != 3'h0))
    else $error("vector form wrong");
  window_hold_a:
  assert property (!trap_take && !trap_return && !win_save && !win_restore
    && !pr_wr_en |=> $stable(current_window_index))
    else $error("window index moved");
  save_step_a:
  assert property (win_save && !trap_take && !trap_return && !pr_wr_en
    |=> current_window_index == $past(current_window_index) + 3'h1 ||
    win_spill_exc || win_clean_exc) else $error("save step wrong");
  reset_depth_a:
  assert property ($rose(rst_n) |-> trap_depth == 3'h5)
    else $error("reset depth");
endmodule

// ---- verification/tsw_trap_window_regs_test.sv ----
// Purpose: Bench for trap and window registers
// Assumes: Inputs change at the falling clock edge
// Notes:   Model predicts every result
module tsw_trap_window_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst_n = 1'b0, pr_rd_en = 1'b0, pr_wr_en = 1'b0;
  logic trap_take = 1'b0, trap_spill = 1'b0, trap_fill = 1'b0;
  logic trap_return = 1'b0, win_save = 1'b0, win_restore = 1'b0;
  logic pr_illegal, win_spill_exc, win_fill_exc, win_clean_exc;
  logic [4:0] pr_sel = 5'h00;
  logic [8:0] trap_type = 9'h000;
  logic [7:0] cur_codes = 8'h00, cur_space_id = 8'h00;
  logic [11:0] cur_proc_state = 12'h000;
  logic [39:0] ret_saved_state;
  logic [2:0] trap_depth, current_window_index;
  logic [63:0] pr_wdata = 64'h0, pr_rdata, trap_vector;
  logic [63:0] seed = 64'h0000_bcc0;
  logic [63:0] m [32];
  logic [63:0] m_st [6];
  logic [63:0] m_kd [6];
  int err_count = 0;
  int checks_done = 0;
  tsw_trap_window_regs i_dut (.*);
  // Free-running clock
  always #5 core_clk = ~core_clk;
  // ****************************************************************
  // Helpers and model
  // ****************************************************************
  function automatic logic [63:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed;
  endfunction
  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One privileged access, answer valid on return
  task automatic acc(bit wr, logic [4:0] s, logic [63:0] d);
    @(negedge core_clk);
    pr_rd_en = !wr;
    pr_wr_en = wr;
    pr_sel = s;
    pr_wdata = d;
    @(negedge core_clk);
    pr_rd_en = 1'b0;
    pr_wr_en = 1'b0;
  endtask
  // Model read value
  function automatic logic [63:0] model(logic [4:0] s);
    if (s == 5'h02) return m_st[m[7]];
    if (s == 5'h03) return m_kd[m[7]];
    if (s == 5'h1f) return 64'h0000_0001_0100_0507;
    return m[s];
  endfunction
  task automatic wr(logic [4:0] s, logic [63:0] d);
    acc(1'b1, s, d);
    case (s)
      5'h02: m_st[m[7]] = d & 64'hff_ff0f_ff07;
      5'h03: m_kd[m[7]] = d & 64'h1ff;
      5'h05: m[s] = d & ~64'h7fff;
      5'h07: m[s] = (d > 5) ? 64'h5 : d;
      5'h0e: m[s] = d & 64'h3f;
      default: m[s] = d & 64'h7;
    endcase
  endtask
  task automatic rd(logic [4:0] s, bit ill);
    acc(1'b0, s, 64'h0);
    chk("illegal", 64'(pr_illegal), 64'(ill));
    chk("rdata", pr_rdata, ill ? 64'h0 : model(s));
  endtask
  task automatic ev(logic [3:0] v);
    @(negedge core_clk);
    {trap_take, trap_return, win_save, win_restore} = v;
    @(negedge core_clk);
    {trap_take, trap_return, win_save, win_restore} = 4'h0;
  endtask
  task automatic trap(bit sp, bit fl);
    logic [63:0] k, st;
    int d, nd;
    d = int'(m[7]);
    nd = (d == 5) ? 5 : d + 1;
    trap_type = 9'(rnd());
    cur_codes = 8'(rnd());
    cur_space_id = 8'(rnd());
    cur_proc_state = 12'(rnd());
    trap_spill = sp;
    trap_fill = fl;
    k = 64'(trap_type);
    if (sp || fl) k[4:2] = (m[13] == 0) ? m[14][2:0] : m[14][5:3];
    st = {24'h0, cur_codes, cur_space_id, 4'h0, cur_proc_state, 5'h0,
      m[9][2:0]};
    if (sp) m[9] = (m[9] + m[10] + 2) & 64'h7;
    if (fl) m[9] = (m[9] - 1) & 64'h7;
    ev(4'h8);
    trap_spill = 1'b0;
    trap_fill = 1'b0;
    chk("vector", trap_vector, {m[5][63:15], d != 0, k[8:0], 5'h0});
    chk("depth", 64'(trap_depth), 64'(nd));
    chk("window", 64'(current_window_index), m[9]);
    chk("saved", 64'(ret_saved_state), st);
    m[7] = 64'(nd);
    m_st[nd] = st;
    m_kd[nd] = k;
  endtask
  task automatic win(bit sv);
    logic [2:0] e;
    e = 3'h0;
    if (sv && m[10] == 0) e = 3'h4;
    else if (sv && m[12] == m[11]) e = 3'h1;
    else if (!sv && m[11] == 0) e = 3'h2;
    else begin
      m[9] = (sv ? m[9] + 1 : m[9] - 1) & 64'h7;
      m[10] = sv ? m[10] - 1 : m[10] + 1;
      m[11] = sv ? m[11] + 1 : m[11] - 1;
    end
    ev(sv ? 4'h2 : 4'h1);
    chk("exc", 64'({win_spill_exc, win_fill_exc, win_clean_exc}), 64'(e));
    chk("window", 64'(current_window_index), m[9]);
  endtask
  // Hang guard
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    foreach (m[i]) m[i] = 64'h0;
    m[7] = 64'h5;
    m_kd[5] = 64'h1;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    rd(5'h07, 1'b0);
    rd(5'h03, 1'b0);
    rd(5'h1f, 1'b0);
    acc(1'b1, 5'h1f, rnd());
    chk("ver write", 64'(pr_illegal), 64'h1);
    rd(5'h1e, 1'b1);
    $display("test reset done");
    for (int s = 9; s <= 14; s++) begin
      wr(5'(s), rnd() & ~64'h1);
      rd(5'(s), 1'b0);
    end
    wr(5'h05, rnd());
    rd(5'h05, 1'b0);
    wr(5'h07, 64'h7);
    rd(5'h07, 1'b0);
    wr(5'h02, rnd());
    rd(5'h02, 1'b0);
    $display("test registers done");
    wr(5'h07, 64'h0);
    rd(5'h02, 1'b1);
    rd(5'h03, 1'b1);
    acc(1'b1, 5'h02, rnd());
    chk("write at zero", 64'(pr_illegal), 64'h1);
    $display("test depth zero done");
    trap(1'b0, 1'b0);
    rd(5'h02, 1'b0);
    rd(5'h03, 1'b0);
    wr(5'h0d, 64'h0);
    wr(5'h0e, rnd());
    trap(1'b1, 1'b0);
    rd(5'h03, 1'b0);
    wr(5'h0d, 64'h1);
    trap(1'b0, 1'b1);
    repeat (3) trap(1'b0, 1'b0);
    rd(5'h03, 1'b0);
    $display("test traps done");
    wr(5'h09, 64'h3);
    wr(5'h0a, 64'h2);
    wr(5'h0c, 64'h3);
    wr(5'h0b, 64'h0);
    repeat (3) win(1'b1);
    repeat (3) win(1'b0);
    wr(5'h0a, 64'h2);
    wr(5'h0b, 64'h1);
    wr(5'h0c, 64'h1);
    win(1'b1);
    $display("test windows done");
    end_sim();
  end
endmodule
bind tsw_trap_window_regs tsw_trap_window_properties i_props (.*);
